// ---- tcp_map.vh ----
// Register map, field positions, reset values and codes for the Type-C source port control
`ifndef TCP_MAP_VH
`define TCP_MAP_VH

// APB byte offsets
`define TCP_CTRL_ADDR      12'h000
`define TCP_STATUS_ADDR    12'h004
`define TCP_INT_STAT_ADDR  12'h008
`define TCP_INT_MASK_ADDR  12'h00c

// Control register
`define TCP_CTRL_DET_EN    0
`define TCP_CTRL_RESET     1'h1

// Status register fields
`define TCP_ST_STATE_LO    0
`define TCP_ST_STATE_HI    2
`define TCP_ST_ORIENT      3
`define TCP_ST_VCONN       4
`define TCP_ST_VBUS        5
`define TCP_ST_LOAD        6
`define TCP_ST_ADV_LO      7
`define TCP_ST_ADV_HI      8
`define TCP_ST_AUDIO       9
`define TCP_ST_DEBUG       10

// Interrupt status and mask bits
`define TCP_EV_ATTACH      0
`define TCP_EV_DETACH      1
`define TCP_EV_LOAD_ON     2
`define TCP_EV_LOAD_OFF    3
`define TCP_EV_AUDIO       4
`define TCP_EV_DEBUG       5
`define TCP_EV_W           6
`define TCP_MASK_RESET     6'h00

// CC comparator codes
`define TCP_CC_OPEN        2'h0
`define TCP_CC_RD          2'h1
`define TCP_CC_RA          2'h2

// Advertisement levels driven to the CC current source
`define TCP_ADV_OFF        2'h0
`define TCP_ADV_DEFAULT    2'h1
`define TCP_ADV_MEDIUM     2'h2
`define TCP_ADV_HIGH       2'h3

// Default debounce length in clock cycles
`define TCP_DEBOUNCE_CYC   20000

`endif

// ---- tcp_sync.v ----
// Two-flop synchroniser for a bundle of pin-level inputs
`timescale 1ns/10ps
module tcp_sync
#(
   parameter W = 8
)
(
   input  wire         clk,   // System clock
   input  wire         rst,   // Asynchronous reset, active high
   input  wire [W-1:0] d,     // Asynchronous pin levels
   output wire [W-1:0] q      // Synchronised levels
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // First stage feeds only the second stage
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule

// ---- tcp_port_ctrl.v ----
// Type-C source port controller: attach sequencing, flags, advertisement and APB registers
//
// Overview of operation
// RQ1: Orientation flag low for CC2 sink, released CC1.
// RQ2: Orientation flag released when nothing attached.
// RQ3: Enable low opens switches, flags, stops monitoring.
// RQ4: Enable high runs device, low stops it.
// RQ5: Load detection only when both selects high.
// RQ6: High-load flag low while current over threshold.
// RQ7: High-load flag released below threshold or unattached.
// RQ8: Attach flag low while sink seen on CC.
// RQ9: High select low lowers advertisement to medium.
// RQ10: Sink cuts current within 60 ms of change.
// RQ11: Wait for logic supply, then sample enable.
// RQ12: Stable sink for debounce, then VBUS on.
// RQ13: VCONN applied to unused pin showing Ra.
// RQ14: VBUS only while attached, removed on detach.
// RQ15: Advertise current level from two select inputs.
// RQ16: Audio flag on both Ra, off CC2 leaves Ra.
// RQ17: Debug flag on both Rd, off CC1 leaves Rd.
// RQ18: Synchronised comparator inputs, debounce parameter in cycles.
// RQ19: Loss of sink or enable returns to unattached.
`timescale 1ns/10ps
`include "tcp_map.vh"
module tcp_port_ctrl
#(
   parameter DEBOUNCE_CYC = `TCP_DEBOUNCE_CYC
)
(
   input  wire        clk,                   // System clock, 50 MHz
   input  wire        rst,                   // Asynchronous reset, active high
   input  wire        psel,                  // APB select
   input  wire        penable,               // APB access phase
   input  wire        pwrite,                // APB direction, high for write
   input  wire [11:0] paddr,                 // APB byte address
   input  wire [31:0] pwdata,                // APB write data
   output reg  [31:0] prdata,                // APB read data
   output reg         pready,                // APB ready
   output reg         pslverr,               // APB error on unmapped address
   output reg         irq,                   // Level interrupt, high active
   input  wire        logic_supply_level,    // Logic supply above lockout
   input  wire        enable_in,             // Run/stop control, high runs
   input  wire        adv_level_select,      // Advertisement select, low for default
   input  wire        adv_high_select,       // High-current select, low caps at medium
   input  wire [1:0]  cc1_level,             // CC1 comparator class
   input  wire [1:0]  cc2_level,             // CC2 comparator class
   input  wire        load_over,             // Sink current above load threshold
   output reg         vbus_switch_en,        // Main switch feeding VBUS
   output reg         vconn_cc1_en,          // VCONN onto CC1
   output reg         vconn_cc2_en,          // VCONN onto CC2
   output reg  [1:0]  adv_level,             // Current advertised on active CC
   output reg         cc_monitor_en,         // CC monitor block powered
   output reg         orientation_flag_n_o,  // Orientation flag level, always low
   output reg         orientation_flag_n_oe, // Orientation flag pulls low
   output reg         attach_flag_n_o,       // Attach flag level, always low
   output reg         attach_flag_n_oe,      // Attach flag pulls low
   output reg         high_load_flag_n_o,    // High-load flag level, always low
   output reg         high_load_flag_n_oe,   // High-load flag pulls low
   output reg         audio_flag_n_o,        // Audio flag level, always low
   output reg         audio_flag_n_oe,       // Audio flag pulls low
   output reg         debug_flag_n_o,        // Debug flag level, always low
   output reg         debug_flag_n_oe        // Debug flag pulls low
);

   localparam [2:0] ST_OFF    = 3'h0;
   localparam [2:0] ST_UNATT  = 3'h1;
   localparam [2:0] ST_DEBNC  = 3'h2;
   localparam [2:0] ST_ATTACH = 3'h3;
   localparam [2:0] ST_AUDIO  = 3'h4;
   localparam [2:0] ST_DEBUG  = 3'h5;
   localparam integer DEB_LAST_I = DEBOUNCE_CYC - 1;
   localparam [23:0]  DEB_LAST   = DEB_LAST_I[23:0];

   wire [8:0] pin_s;
   wire       aux_s;
   wire       en_s;
   wire       lvl_s;
   wire       hi_s;
   wire       over_s;
   wire [1:0] cc1_s;
   wire [1:0] cc2_s;

   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg  [23:0] deb_q;
   reg  [23:0] deb_d;
   reg  [3:0]  cc_last_q;
   reg         orient_q;
   reg         orient_d;
   reg         ctrl_det_q;
   reg  [5:0]  int_stat_q;
   reg  [5:0]  int_mask_q;
   reg         load_q;
   reg  [5:0]  ev;
   reg  [10:0] status;
   reg  [31:0] rd_mux;
   reg         addr_ok;

   // Pins are asynchronous, so every one passes two flops first
   tcp_sync #(.W(9)) u_sync
   (
      .clk (clk),
      .rst (rst),
      .d   ({logic_supply_level, enable_in, adv_level_select, adv_high_select,
             load_over, cc1_level, cc2_level}),
      .q   (pin_s)
   );

   assign aux_s  = pin_s[8];
   assign en_s   = pin_s[7];
   assign lvl_s  = pin_s[6];
   assign hi_s   = pin_s[5];
   assign over_s = pin_s[4];
   assign cc1_s  = pin_s[3:2];
   assign cc2_s  = pin_s[1:0];

   // Classification of the synchronised CC pair
   wire sink_cc1  = (cc1_s == `TCP_CC_RD) && (cc2_s != `TCP_CC_RD);
   wire sink_cc2  = (cc2_s == `TCP_CC_RD) && (cc1_s != `TCP_CC_RD);
   wire both_ra   = (cc1_s == `TCP_CC_RA) && (cc2_s == `TCP_CC_RA);
   wire both_rd   = (cc1_s == `TCP_CC_RD) && (cc2_s == `TCP_CC_RD);
   wire candidate = sink_cc1 | sink_cc2 | both_ra | both_rd;
   wire stable    = ({cc1_s, cc2_s} == cc_last_q);
   wire run       = aux_s & en_s & ctrl_det_q;     // RQ3 RQ4
   wire sink_kept = orient_q ? (cc2_s == `TCP_CC_RD) : (cc1_s == `TCP_CC_RD);

   // Attach sequencer
   always @*
   begin
      state_d  = state_q;
      deb_d    = deb_q;
      orient_d = orient_q;
      case (state_q)
         ST_OFF:
         begin
            deb_d = 24'h000000;
            // Enable is only looked at once the logic supply is good
            if (aux_s && en_s && ctrl_det_q)                          // RQ11
               state_d = ST_UNATT;
         end
         ST_UNATT:
         begin
            deb_d = 24'h000000;
            if (candidate)
               state_d = ST_DEBNC;
         end
         ST_DEBNC:
         begin
            // Any change of the pair restarts the wait
            if (!candidate || !stable)                                // RQ18
               state_d = ST_UNATT;
            else if (deb_q == DEB_LAST)                               // RQ12
            begin
               if (both_ra)
                  state_d = ST_AUDIO;                                 // RQ16
               else if (both_rd)
                  state_d = ST_DEBUG;                                 // RQ17
               else
               begin
                  state_d  = ST_ATTACH;
                  orient_d = sink_cc2;
               end
            end
            else
               deb_d = deb_q + 24'h000001;
         end
         ST_ATTACH:
         begin
            if (!sink_kept)                                           // RQ14 RQ19
               state_d = ST_UNATT;
         end
         ST_AUDIO:
         begin
            // Only CC2 is watched for the audio detach
            if (cc2_s != `TCP_CC_RA)                                  // RQ16
               state_d = ST_UNATT;
         end
         ST_DEBUG:
         begin
            // Only CC1 is watched for the debug detach
            if (cc1_s != `TCP_CC_RD)                                  // RQ17
               state_d = ST_UNATT;
         end
         default:
            state_d = ST_OFF;
      endcase
      // Losing supply, enable or software detection drops everything
      if (!run)                                                       // RQ3 RQ19
         state_d = ST_OFF;
   end

   // Sequencer registers
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q   <= ST_OFF;
         deb_q     <= 24'h000000;
         orient_q  <= 1'b0;
         cc_last_q <= 4'h0;
      end
      else
      begin
         state_q   <= state_d;
         deb_q     <= deb_d;
         orient_q  <= orient_d;
         cc_last_q <= {cc1_s, cc2_s};
      end
   end

   // Next values of the outward controls, all forced off outside their states
   wire attached_d = (state_d == ST_ATTACH);
   wire load_en_d  = attached_d && lvl_s && hi_s;                     // RQ5
   wire load_d     = load_en_d && over_s;                             // RQ6 RQ7
   wire ra_other   = orient_d ? (cc1_s == `TCP_CC_RA) : (cc2_s == `TCP_CC_RA);
   reg  [1:0] adv_d;

   // Advertisement from the two selects; high select low caps at medium
   always @*
   begin
      if (state_d == ST_OFF)
         adv_d = `TCP_ADV_OFF;                                        // RQ3
      else if (!lvl_s)
         adv_d = `TCP_ADV_DEFAULT;                                    // RQ15
      else if (!hi_s)
         adv_d = `TCP_ADV_MEDIUM;                                     // RQ9
      else
         adv_d = `TCP_ADV_HIGH;                                       // RQ15
   end

   // Output flops
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         vbus_switch_en        <= 1'b0;
         vconn_cc1_en          <= 1'b0;
         vconn_cc2_en          <= 1'b0;
         adv_level             <= `TCP_ADV_OFF;
         cc_monitor_en         <= 1'b0;
         orientation_flag_n_oe <= 1'b0;
         attach_flag_n_oe      <= 1'b0;
         high_load_flag_n_oe   <= 1'b0;
         audio_flag_n_oe       <= 1'b0;
         debug_flag_n_oe       <= 1'b0;
         orientation_flag_n_o  <= 1'b0;
         attach_flag_n_o       <= 1'b0;
         high_load_flag_n_o    <= 1'b0;
         audio_flag_n_o        <= 1'b0;
         debug_flag_n_o        <= 1'b0;
         load_q                <= 1'b0;
      end
      else
      begin
         vbus_switch_en        <= attached_d;                         // RQ12 RQ14
         vconn_cc1_en          <= attached_d && orient_d && ra_other; // RQ13
         vconn_cc2_en          <= attached_d && !orient_d && ra_other;// RQ13
         adv_level             <= adv_d;
         cc_monitor_en         <= (state_d != ST_OFF);                // RQ3
         orientation_flag_n_oe <= attached_d && orient_d;             // RQ1 RQ2
         attach_flag_n_oe      <= attached_d;                         // RQ8
         high_load_flag_n_oe   <= load_d;                             // RQ6 RQ7
         audio_flag_n_oe       <= (state_d == ST_AUDIO);              // RQ16
         debug_flag_n_oe       <= (state_d == ST_DEBUG);              // RQ17
         load_q                <= load_d;
      end
   end

   // Events for the interrupt status
   always @*
   begin
      ev = 6'h00;
      ev[`TCP_EV_ATTACH]   = attached_d && (state_q != ST_ATTACH);
      ev[`TCP_EV_DETACH]   = !attached_d && (state_q == ST_ATTACH);
      ev[`TCP_EV_LOAD_ON]  = load_d && !load_q;
      ev[`TCP_EV_LOAD_OFF] = !load_d && load_q;
      ev[`TCP_EV_AUDIO]    = (state_d == ST_AUDIO) && (state_q != ST_AUDIO);
      ev[`TCP_EV_DEBUG]    = (state_d == ST_DEBUG) && (state_q != ST_DEBUG);
   end

   // Live status word
   always @*
   begin
      status = 11'h000;
      status[`TCP_ST_STATE_HI:`TCP_ST_STATE_LO] = state_q;
      status[`TCP_ST_ORIENT]                    = orientation_flag_n_oe;
      status[`TCP_ST_VCONN]                     = vconn_cc1_en | vconn_cc2_en;
      status[`TCP_ST_VBUS]                      = vbus_switch_en;
      status[`TCP_ST_LOAD]                      = high_load_flag_n_oe;
      status[`TCP_ST_ADV_HI:`TCP_ST_ADV_LO]     = adv_level;
      status[`TCP_ST_AUDIO]                     = audio_flag_n_oe;
      status[`TCP_ST_DEBUG]                     = debug_flag_n_oe;
   end

   // Read multiplexer and address decode
   always @*
   begin
      rd_mux  = 32'h00000000;
      addr_ok = 1'b1;
      case (paddr)
         `TCP_CTRL_ADDR:     rd_mux = {31'h00000000, ctrl_det_q};
         `TCP_STATUS_ADDR:   rd_mux = {21'h000000, status};
         `TCP_INT_STAT_ADDR: rd_mux = {26'h0000000, int_stat_q};
         `TCP_INT_MASK_ADDR: rd_mux = {26'h0000000, int_mask_q};
         default:            addr_ok = 1'b0;
      endcase
   end

   // One wait state: ready rises in the second access cycle
   wire access = psel && penable && !pready;
   wire done   = psel && penable && pready;
   wire wr     = done && pwrite;
   wire rd_int = done && !pwrite && (paddr == `TCP_INT_STAT_ADDR);
   // Mask as it stands after this edge, so irq follows a mask write at once
   wire [5:0] mask_d = (wr && paddr == `TCP_INT_MASK_ADDR) ?
                       pwdata[`TCP_EV_W-1:0] : int_mask_q;

   // APB slave and register file
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= 32'h00000000;
         ctrl_det_q <= `TCP_CTRL_RESET;
         int_mask_q <= `TCP_MASK_RESET;
         int_stat_q <= 6'h00;
         irq        <= 1'b0;
      end
      else
      begin
         pready  <= access;
         pslverr <= access && !addr_ok;
         if (access && !pwrite)
            prdata <= rd_mux;
         if (wr && paddr == `TCP_CTRL_ADDR)
            ctrl_det_q <= pwdata[`TCP_CTRL_DET_EN];
         if (wr && paddr == `TCP_INT_MASK_ADDR)
            int_mask_q <= pwdata[`TCP_EV_W-1:0];
         // Read clears, but an event in the same cycle is kept
         int_stat_q <= (rd_int ? 6'h00 : int_stat_q) | ev;
         irq        <= |(((rd_int ? 6'h00 : int_stat_q) | ev) & mask_d);
      end
   end

endmodule

// ---- tcp_props.sv ----
// Concurrent checks on the Type-C source port controller ports
`timescale 1ns/10ps
`include "tcp_map.vh"
module tcp_props
#(
   parameter DEBOUNCE_CYC = 8
)
(
   input wire       clk,                   // System clock
   input wire       rst,                   // Asynchronous reset
   input wire       psel,                  // APB select
   input wire       penable,               // APB access phase
   input wire       pready,                // APB ready
   input wire       enable_in,             // Run/stop pin
   input wire [1:0] cc1_level,             // CC1 class
   input wire [1:0] cc2_level,             // CC2 class
   input wire       vbus_switch_en,        // VBUS switch
   input wire       vconn_cc1_en,          // VCONN on CC1
   input wire       vconn_cc2_en,          // VCONN on CC2
   input wire [1:0] adv_level,             // Advertisement
   input wire       cc_monitor_en,         // Monitor powered
   input wire       orientation_flag_n_oe, // Orientation pull
   input wire       attach_flag_n_oe,      // Attach pull
   input wire       high_load_flag_n_oe,   // High-load pull
   input wire       audio_flag_n_oe,       // Audio pull
   input wire       debug_flag_n_oe        // Debug pull
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_orient_needs_attach: assert property (orientation_flag_n_oe |-> attach_flag_n_oe)
      else $error("orientation flag while unattached");
   a_off_all_quiet: assert property (!cc_monitor_en |-> !(vbus_switch_en | vconn_cc1_en
      | vconn_cc2_en | orientation_flag_n_oe | attach_flag_n_oe | high_load_flag_n_oe
      | audio_flag_n_oe | debug_flag_n_oe) && adv_level == `TCP_ADV_OFF)
      else $error("output active while monitor off");
   a_enable_stops: assert property ($fell(enable_in) |-> ##[1:4] !cc_monitor_en)
      else $error("enable low did not stop the port");
   a_load_needs_high: assert property (high_load_flag_n_oe |-> adv_level == `TCP_ADV_HIGH)
      else $error("high-load flag without high advertisement");
   a_vconn_one_pin: assert property (!(vconn_cc1_en && vconn_cc2_en))
      else $error("VCONN on both pins");
   a_vbus_needs_sink: assert property (vbus_switch_en |-> attach_flag_n_oe
      && !audio_flag_n_oe && !debug_flag_n_oe)
      else $error("VBUS without attached sink");
   a_debounce_held: assert property ($rose(vbus_switch_en) |->
      $past(cc1_level, 3) == $past(cc1_level, DEBOUNCE_CYC)
      && $past(cc2_level, 3) == $past(cc2_level, DEBOUNCE_CYC))
      else $error("VBUS on before CC stable");
   a_audio_both_ra: assert property ($rose(audio_flag_n_oe) |->
      $past(cc1_level, 3) == `TCP_CC_RA && $past(cc2_level, 3) == `TCP_CC_RA)
      else $error("audio flag without Ra on both pins");
   a_debug_both_rd: assert property ($rose(debug_flag_n_oe) |->
      $past(cc1_level, 3) == `TCP_CC_RD && $past(cc2_level, 3) == `TCP_CC_RD)
      else $error("debug flag without Rd on both pins");
   a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("APB answer not one wait state");
   a_apb_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
endmodule
bind tcp_port_ctrl tcp_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_props (.clk, .rst, .psel,
   .penable, .pready, .enable_in, .cc1_level, .cc2_level, .vbus_switch_en, .vconn_cc1_en,
   .vconn_cc2_en, .adv_level, .cc_monitor_en, .orientation_flag_n_oe, .attach_flag_n_oe,
   .high_load_flag_n_oe, .audio_flag_n_oe, .debug_flag_n_oe);

// ---- tcp_sink_model.sv ----
// Behavioural attached sink or marked cable: CC terminations and load current
`timescale 1ns/10ps
module tcp_sink_model
#(
   parameter CUT_CYC = 16
)
(
   input  wire       clk,       // System clock
   input  wire       rst,       // Reset
   input  wire [1:0] cc1_sel,   // Termination on CC1
   input  wire [1:0] cc2_sel,   // Termination on CC2
   input  wire       draw_hi,   // Sink wants current above threshold
   input  wire       greedy,    // Sink ignores the advertisement
   input  wire [1:0] adv_level, // Advertisement seen on CC
   input  wire       vbus_on,   // VBUS present
   output wire [1:0] cc1_level, // CC1 comparator class
   output wire [1:0] cc2_level, // CC2 comparator class
   output wire       load_over  // Current above threshold
);
   reg [7:0] cut_q;
   // Grace count after high advertisement ends; far below the real allowance
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         cut_q <= 8'h00;
      else if (adv_level == 2'h3)
         cut_q <= 8'(CUT_CYC);
      else if (cut_q != 8'h00)
         cut_q <= cut_q - 8'h01;
   end
   // Heavy draw only with VBUS up, and while the advertisement still allows it unless greedy
   assign load_over = vbus_on & draw_hi & (greedy | adv_level == 2'h3 | cut_q != 8'h00);
   assign cc1_level = cc1_sel;
   assign cc2_level = cc2_sel;
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the Type-C source port controller
`timescale 1ns/10ps
`include "tcp_map.vh"
`define CHK(nm, ex, ac) begin n_compared++; if ((ac) !== (ex)) begin error_cnt++; \
   $display("mismatch %s exp %h got %h", nm, ex, ac); end end
module tb_top;
   reg         clk, rst, psel, penable, pwrite, aux, en, lvl_sel, hi_sel, draw_hi, greedy, e;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, r;
   reg  [1:0]  cc1, cc2;
   wire [31:0] prdata;
   wire        pready, pslverr, irq, vbus, vc1, vc2, mon, ld;
   wire [1:0]  adv, cc1_l, cc2_l;
   wire        or_o, or_oe, at_o, at_oe, hl_o, hl_oe, au_o, au_oe, db_o, db_oe;
   wire [6:0]  vec = {vbus, vc1, vc2, or_oe, at_oe, au_oe, db_oe};
   integer     error_cnt, n_compared, k;
   // Rows: CC1/CC2 terminations, expected outputs, outputs that matter
   localparam [3:0] CCS [0:5] = '{4'h4, 4'h1, 4'h6, 4'h9, 4'ha, 4'h5};
   localparam [6:0] EXP [0:5] = '{7'h44, 7'h4c, 7'h54, 7'h6c, 7'h02, 7'h01};
   localparam [6:0] MSK [0:5] = '{7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f};
   localparam [1:0] ADV [0:3] = '{2'h1, 2'h1, 2'h2, 2'h3};

   tcp_port_ctrl #(.DEBOUNCE_CYC(8)) i_dut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .logic_supply_level(aux),
      .enable_in(en), .adv_level_select(lvl_sel), .adv_high_select(hi_sel),
      .cc1_level(cc1_l), .cc2_level(cc2_l), .load_over(ld), .vbus_switch_en(vbus),
      .vconn_cc1_en(vc1), .vconn_cc2_en(vc2), .adv_level(adv), .cc_monitor_en(mon),
      .orientation_flag_n_o(or_o), .orientation_flag_n_oe(or_oe), .attach_flag_n_o(at_o),
      .attach_flag_n_oe(at_oe), .high_load_flag_n_o(hl_o), .high_load_flag_n_oe(hl_oe),
      .audio_flag_n_o(au_o), .audio_flag_n_oe(au_oe), .debug_flag_n_o(db_o),
      .debug_flag_n_oe(db_oe));
   tcp_sink_model #(.CUT_CYC(16)) i_sink (.clk(clk), .rst(rst), .cc1_sel(cc1), .cc2_sel(cc2),
      .draw_hi(draw_hi), .greedy(greedy), .adv_level(adv), .vbus_on(vbus),
      .cc1_level(cc1_l), .cc2_level(cc2_l), .load_over(ld));

   // 50 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task report_and_stop;
   begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask

   task cyc(input integer n);
      repeat (n) @(posedge clk);
   endtask

   // One APB transfer; the request is held until pready is seen high
   task apb(input w, input [11:0] a, input [31:0] d);
      integer i;
   begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      for (i = 0; pready !== 1'b1 && i < 20; i = i + 1)
         @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 20)
      begin
         error_cnt++;
         report_and_stop;
      end
   end
   endtask

   // Bounded wait for any attached state to show
   task wait_att;
      integer i;
   begin
      for (i = 0; (vbus | au_oe | db_oe) !== 1'b1 && i < 40; i = i + 1)
         @(posedge clk);
      if (i >= 40)
      begin
         error_cnt++;
         report_and_stop;
      end
      cyc(2);
   end
   endtask

   initial
   begin
      error_cnt = 0;
      n_compared = 0;
      {rst, aux, en, lvl_sel, hi_sel} = 5'h1f;
      {psel, penable, pwrite, draw_hi, greedy, paddr, pwdata, cc1, cc2} = 'h0;
      cyc(4);
      rst <= 1'b0;
      cyc(2);
      `CHK("flags", 7'h00, vec)
      apb(0, `TCP_CTRL_ADDR, 0);
      `CHK("ctrl", 32'h1, r)
      apb(0, `TCP_INT_MASK_ADDR, 0);
      `CHK("mask", 32'h0, r)
      apb(0, 12'h010, 0);
      `CHK("unmapped", 33'h100000000, {e, r})
      apb(1, `TCP_CTRL_ADDR, 0);
      cyc(4);
      `CHK("det off", 1'b0, mon)
      apb(1, `TCP_CTRL_ADDR, 1);
      $display("test reset done");
      for (k = 0; k < 6; k++)
      begin
         cc1 <= CCS[k][3:2];
         cc2 <= CCS[k][1:0];
         wait_att;
         `CHK("attach", EXP[k], vec & MSK[k])
         // Pull the pin that the attached state watches
         if (k == 1 || k == 3 || k == 4)
            cc2 <= 2'h0;
         else
            cc1 <= 2'h0;
         cyc(5);
         `CHK("detach", 7'h00, vec)
      end
      $display("test rows done");
      cc1 <= `TCP_CC_RD;
      cc2 <= 2'h0;
      wait_att;
      for (k = 0; k < 4; k++)
      begin
         lvl_sel <= k[1];
         hi_sel <= k[0];
         cyc(4);
         `CHK("adv", ADV[k], adv)
      end
      draw_hi <= 1'b1;
      cyc(5);
      `CHK("load on", 1'b1, hl_oe)
      draw_hi <= 1'b0;
      cyc(5);
      `CHK("load off", 1'b0, hl_oe)
      {greedy, draw_hi, hi_sel} <= 3'h6;
      cyc(5);
      `CHK("load med", 1'b0, hl_oe)
      {greedy, draw_hi, hi_sel} <= 3'h1;
      $display("test load done");
      en <= 1'b0;
      cyc(5);
      `CHK("off", 10'h000, {vec, mon, adv})
      aux <= 1'b0;
      cyc(3);
      aux <= 1'b1;
      cyc(5);
      `CHK("start en low", 1'b0, mon)
      en <= 1'b1;
      wait_att;
      `CHK("rerun", 1'b1, vbus)
      `CHK("flag levels", 5'h00, {or_o, at_o, hl_o, au_o, db_o})
      apb(0, `TCP_STATUS_ADDR, 0);
      `CHK("status", 32'h1a3, r)
      $display("test enable done");
      apb(1, `TCP_INT_MASK_ADDR, 32'h1);
      apb(0, `TCP_INT_STAT_ADDR, 0);
      cc1 <= 2'h0;
      cyc(5);
      `CHK("irq masked", 1'b0, irq)
      apb(0, `TCP_INT_STAT_ADDR, 0);
      `CHK("detach ev", 1'b1, r[`TCP_EV_DETACH])
      cc1 <= `TCP_CC_RD;
      wait_att;
      `CHK("irq", 1'b1, irq)
      apb(0, `TCP_INT_STAT_ADDR, 0);
      `CHK("attach ev", 1'b1, r[`TCP_EV_ATTACH])
      cyc(2);
      `CHK("irq clear", 1'b0, irq)
      apb(0, `TCP_INT_STAT_ADDR, 0);
      `CHK("stat clear", 32'h0, r)
      $display("test irq done");
      report_and_stop;
   end
endmodule
